//--- logic/eirq_top.v
// What this block does
// - A low on the interrupt pin sets the request latch, per sensitivity mode.
// - Vector fetch, software acknowledge or reset clears the latch.
// - Level mode: latch clears only after acknowledge and pin back high.
// - Level mode: acknowledge and pin return may happen in either order.
// - Level mode: request stays pending while the pin is low.
// - Edge mode: vector fetch or acknowledge clears the latch at once.
// - Writing one to the acknowledge bit clears the latch; it reads zero.
// - A falling edge after an acknowledge latches a new request.
// - Unmasked taken request makes the CPU fetch the vector at FFFA/FFFB.
// - Mask bit blocks requests when one, passes them when zero; reset clears.
// - Level sense select: one means edge and level, zero edge only.
// - Read-only event flag shows whether an interrupt event occurred.
// - Current pin level is offered to the CPU for branch tests.
// - Block works in wait; unmasked request wakes the core.
// - Block works in stop; unmasked request wakes the core.
// - In break, software clear only with break clear enable set; stays cleared.
// - With break clear enable zero, software acknowledges in break do nothing; a vector fetch still clears.
`timescale 1ns/100ps
`include "eirq_consts.vh"
module eirq_top #(
   parameter ADDR_W = 4,
   parameter [15:0] VECTOR_ADDR = 16'hfffa
) (
   // Clock and reset.
   input wire core_clk,
   input wire reset,
   // AXI4-Lite write address channel.
   input wire [ADDR_W-1:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output wire s_axi_awready,
   // AXI4-Lite write data channel.
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output wire s_axi_wready,
   // AXI4-Lite write response channel.
   output wire [1:0] s_axi_bresp,
   output wire s_axi_bvalid,
   input wire s_axi_bready,
   // AXI4-Lite read address channel.
   input wire [ADDR_W-1:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output wire s_axi_arready,
   // AXI4-Lite read data channel.
   output wire [31:0] s_axi_rdata,
   output wire [1:0] s_axi_rresp,
   output wire s_axi_rvalid,
   input wire s_axi_rready,
   // External interrupt pin, active low.
   input wire ext_irq_n,
   // CPU side.
   input wire vector_fetch,
   input wire break_state,
   input wire wait_mode,
   input wire stop_mode,
   output wire cpu_irq_req,
   output wire [15:0] cpu_vector_addr,
   output wire pin_level_to_cpu,
   output wire wake_req,
   // Interrupt output to the system.
   output wire irq_out
);
   // Bus state.
   reg aw_held_reg;
   reg [ADDR_W-1:0] aw_addr_reg;
   reg w_held_reg;
   reg [31:0] w_data_reg;
   reg [3:0] w_strb_reg;
   reg bvalid_reg;
   reg [1:0] bresp_reg;
   reg rvalid_reg;
   reg [31:0] rdata_reg;
   reg [1:0] rresp_reg;
   // Software visible state.
   reg level_sense_select_reg;
   reg request_mask_bit_reg;
   reg break_clear_enable_reg;
   reg [`EIRQ_EV_W-1:0] irq_status_reg;
   reg [`EIRQ_EV_W-1:0] irq_mask_reg;
   reg ext_event_flag_reg;
   reg latch_prev_reg;
   reg wake_prev_reg;

   wire pin_level;
   wire fall_pulse;
   wire latch_state;
   wire write_fire;
   wire read_fire;
   wire ack_write;
   wire sw_clear_ok;
   wire clear_req;
   wire wake_raw;
   wire [`EIRQ_EV_W-1:0] ev_set;
   wire status_read;

   // True when an offset names a register of this block.
   function mapped;
      input [ADDR_W-1:0] addr;
      begin
         mapped = (addr == `EIRQ_OFF_STATUS_CONTROL) || (addr == `EIRQ_OFF_BREAK_CTRL) ||
            (addr == `EIRQ_OFF_IRQ_STATUS) || (addr == `EIRQ_OFF_IRQ_MASK);
      end
   endfunction

   eirq_pin_sync u_sync (
      .core_clk(core_clk),
      .reset(reset),
      .pin_n(ext_irq_n),
      .pin_level(pin_level),
      .fall_pulse(fall_pulse)
   );

   eirq_latch u_latch (
      .core_clk(core_clk),
      .reset(reset),
      .pin_level(pin_level),
      .fall_pulse(fall_pulse),
      .level_sense_select(level_sense_select_reg),
      .clear_req(clear_req),
      .latch_state(latch_state)
   );

   // Address and data are held until both have arrived, in either order.
   assign s_axi_awready = ~aw_held_reg & ~bvalid_reg;
   assign s_axi_wready = ~w_held_reg & ~bvalid_reg;
   assign write_fire = aw_held_reg & w_held_reg & ~bvalid_reg;
   assign s_axi_bvalid = bvalid_reg;
   assign s_axi_bresp = bresp_reg;
   assign s_axi_arready = ~rvalid_reg;
   assign read_fire = s_axi_arvalid & ~rvalid_reg;
   assign s_axi_rvalid = rvalid_reg;
   assign s_axi_rdata = rdata_reg;
   assign s_axi_rresp = rresp_reg;

   // Acknowledge is a pulse from the write, never stored, so it reads zero.
   assign ack_write = write_fire & (aw_addr_reg == `EIRQ_OFF_STATUS_CONTROL) & w_strb_reg[0] &
      w_data_reg[`EIRQ_BIT_ACK];
   // In break, the software clear is gated by the break clear enable.
   assign sw_clear_ok = ack_write & (~break_state | break_clear_enable_reg);
   // Vector fetch acknowledges only when this request was the one taken.
   assign clear_req = sw_clear_ok | (vector_fetch & cpu_irq_req);

   // Masked latch goes to the CPU priority logic with its vector.
   assign cpu_irq_req = latch_state & ~request_mask_bit_reg;
   assign cpu_vector_addr = VECTOR_ADDR;
   assign pin_level_to_cpu = pin_level;
   // The latch runs from core_clk, which is assumed kept alive in low power modes.
   assign wake_raw = cpu_irq_req & (wait_mode | stop_mode);
   assign wake_req = wake_raw;

   // Sticky events: a new latch and a wake request, both on rising edges.
   assign ev_set[`EIRQ_EV_LATCH] = latch_state & ~latch_prev_reg;
   assign ev_set[`EIRQ_EV_WAKE] = wake_raw & ~wake_prev_reg;
   assign status_read = read_fire & (s_axi_araddr == `EIRQ_OFF_IRQ_STATUS);
   assign irq_out = |(irq_status_reg & irq_mask_reg);

   // Write channel capture and response.
   always @(posedge core_clk or posedge reset) begin
      if (reset) begin
         aw_held_reg <= 1'b0;
         aw_addr_reg <= {ADDR_W{1'b0}};
         w_held_reg <= 1'b0;
         w_data_reg <= 32'h0000_0000;
         w_strb_reg <= 4'h0;
         bvalid_reg <= 1'b0;
         bresp_reg <= `EIRQ_RESP_OKAY;
      end else begin
         if (s_axi_awvalid & s_axi_awready) begin
            aw_held_reg <= 1'b1;
            aw_addr_reg <= s_axi_awaddr;
         end
         if (s_axi_wvalid & s_axi_wready) begin
            w_held_reg <= 1'b1;
            w_data_reg <= s_axi_wdata;
            w_strb_reg <= s_axi_wstrb;
         end
         if (write_fire) begin
            aw_held_reg <= 1'b0;
            w_held_reg <= 1'b0;
            bvalid_reg <= 1'b1;
            bresp_reg <= mapped(aw_addr_reg) ? `EIRQ_RESP_OKAY : `EIRQ_RESP_SLVERR;
         end else if (bvalid_reg & s_axi_bready) begin
            bvalid_reg <= 1'b0;
         end
      end
   end

   // Control register writes; only byte lane zero carries fields.
   always @(posedge core_clk or posedge reset) begin
      if (reset) begin
         level_sense_select_reg <= 1'b0;
         request_mask_bit_reg <= 1'b0;
         break_clear_enable_reg <= 1'b0;
         irq_mask_reg <= {`EIRQ_EV_W{1'b0}};
      end else if (write_fire & w_strb_reg[0]) begin
         case (aw_addr_reg)
            `EIRQ_OFF_STATUS_CONTROL: begin
               level_sense_select_reg <= w_data_reg[`EIRQ_BIT_MODE];
               request_mask_bit_reg <= w_data_reg[`EIRQ_BIT_MASK];
            end
            `EIRQ_OFF_BREAK_CTRL: begin
               break_clear_enable_reg <= w_data_reg[`EIRQ_BIT_BRK_CLR];
            end
            `EIRQ_OFF_IRQ_MASK: begin
               irq_mask_reg <= w_data_reg[`EIRQ_EV_W-1:0];
            end
            default: begin
               irq_mask_reg <= irq_mask_reg;
            end
         endcase
      end
   end

   // Event flag follows the latch, so a clear held off in break keeps it set.
   // Sticky status clears on read, but a same-cycle event wins.
   always @(posedge core_clk or posedge reset) begin
      if (reset) begin
         ext_event_flag_reg <= 1'b0;
         latch_prev_reg <= 1'b0;
         wake_prev_reg <= 1'b0;
         irq_status_reg <= {`EIRQ_EV_W{1'b0}};
      end else begin
         ext_event_flag_reg <= latch_state;
         latch_prev_reg <= latch_state;
         wake_prev_reg <= wake_raw;
         irq_status_reg <= (status_read ? {`EIRQ_EV_W{1'b0}} : irq_status_reg) | ev_set;
      end
   end

   // Read channel; one cycle from address to data.
   always @(posedge core_clk or posedge reset) begin
      if (reset) begin
         rvalid_reg <= 1'b0;
         rdata_reg <= 32'h0000_0000;
         rresp_reg <= `EIRQ_RESP_OKAY;
      end else if (read_fire) begin
         rvalid_reg <= 1'b1;
         rresp_reg <= mapped(s_axi_araddr) ? `EIRQ_RESP_OKAY : `EIRQ_RESP_SLVERR;
         rdata_reg <= 32'h0000_0000;
         case (s_axi_araddr)
            `EIRQ_OFF_STATUS_CONTROL: begin
               rdata_reg[`EIRQ_BIT_MODE] <= level_sense_select_reg;
               rdata_reg[`EIRQ_BIT_MASK] <= request_mask_bit_reg;
               rdata_reg[`EIRQ_BIT_FLAG] <= ext_event_flag_reg;
               rdata_reg[`EIRQ_BIT_PIN] <= pin_level;
            end
            `EIRQ_OFF_BREAK_CTRL: begin
               rdata_reg[`EIRQ_BIT_BRK_CLR] <= break_clear_enable_reg;
            end
            `EIRQ_OFF_IRQ_STATUS: begin
               rdata_reg[`EIRQ_EV_W-1:0] <= irq_status_reg;
            end
            `EIRQ_OFF_IRQ_MASK: begin
               rdata_reg[`EIRQ_EV_W-1:0] <= irq_mask_reg;
            end
            default: begin
               rdata_reg <= 32'h0000_0000;
            end
         endcase
      end else if (rvalid_reg & s_axi_rready) begin
         rvalid_reg <= 1'b0;
      end
   end
endmodule

//--- logic/eirq_consts.vh
`ifndef EIRQ_CONSTS_VH
`define EIRQ_CONSTS_VH
// Register byte offsets on the AXI4-Lite slave.
`define EIRQ_OFF_STATUS_CONTROL 4'h0
`define EIRQ_OFF_BREAK_CTRL 4'h4
`define EIRQ_OFF_IRQ_STATUS 4'h8
`define EIRQ_OFF_IRQ_MASK 4'hc
// Field positions in the status and control register.
`define EIRQ_BIT_MODE 0
`define EIRQ_BIT_MASK 1
`define EIRQ_BIT_ACK 2
`define EIRQ_BIT_FLAG 3
`define EIRQ_BIT_PIN 4
// Field positions in the break flag control register.
`define EIRQ_BIT_BRK_CLR 7
// Sticky event bits.
`define EIRQ_EV_LATCH 0
`define EIRQ_EV_WAKE 1
`define EIRQ_EV_W 2
// Bus responses.
`define EIRQ_RESP_OKAY 2'b00
`define EIRQ_RESP_SLVERR 2'b10
`endif

//--- logic/eirq_pin_sync.v
`timescale 1ns/100ps
// Two-stage synchroniser with falling-edge detection on the second stage only.
module eirq_pin_sync (
   // Clock and reset.
   input wire core_clk,
   input wire reset,
   // Pin in, clean level and edge out.
   input wire pin_n,
   output wire pin_level,
   output wire fall_pulse
);
   reg meta_reg;
   reg sync_reg;
   reg prev_reg;

   // The pin idles high, so the chain resets to one to avoid a fake edge.
   always @(posedge core_clk or posedge reset) begin
      if (reset) begin
         meta_reg <= 1'b1;
         sync_reg <= 1'b1;
         prev_reg <= 1'b1;
      end else begin
         meta_reg <= pin_n;
         sync_reg <= meta_reg;
         prev_reg <= sync_reg;
      end
   end

   // Edge taken from synchronised stages so one fall gives exactly one pulse.
   assign pin_level = sync_reg;
   assign fall_pulse = prev_reg & ~sync_reg;
endmodule

//--- logic/eirq_latch.v
`timescale 1ns/100ps
// The request latch with its edge and level sensitivity.
module eirq_latch (
   // Clock and reset.
   input wire core_clk,
   input wire reset,
   // Pin view.
   input wire pin_level,
   input wire fall_pulse,
   // Controls.
   input wire level_sense_select,
   input wire clear_req,
   // State.
   output wire latch_state
);
   reg latch_reg;
   reg ack_seen_reg;
   reg latch_next;
   reg ack_seen_next;

   // Level mode waits for both acknowledge and pin high, in either order.
   always @* begin
      latch_next = latch_reg;
      ack_seen_next = ack_seen_reg;
      if (level_sense_select) begin
         if (clear_req & latch_reg) begin
            ack_seen_next = 1'b1;
         end
         if ((ack_seen_next | clear_req) & pin_level & latch_reg) begin
            latch_next = 1'b0;
            ack_seen_next = 1'b0;
         end
         if (!pin_level) begin
            latch_next = 1'b1;
         end
      end else begin
         ack_seen_next = 1'b0;
         if (clear_req) begin
            latch_next = 1'b0;
         end
      end
      // A new edge wins over a clear in the same cycle.
      if (fall_pulse) begin
         latch_next = 1'b1;
         ack_seen_next = 1'b0;
      end
   end

   // Reset clears the latch.
   always @(posedge core_clk or posedge reset) begin
      if (reset) begin
         latch_reg <= 1'b0;
         ack_seen_reg <= 1'b0;
      end else begin
         latch_reg <= latch_next;
         ack_seen_reg <= ack_seen_next;
      end
   end

   assign latch_state = latch_reg;
endmodule

//--- dv/eip_monitor.sv
`timescale 1ns/100ps
// Watches the top ports for wake, pin, vector and bus answer relations.
module eip_monitor (
   // Clock and reset.
   input wire core_clk,
   input wire reset,
   // Bus handshakes.
   input wire s_axi_awready,
   input wire s_axi_bvalid,
   input wire s_axi_bready,
   input wire s_axi_arvalid,
   input wire s_axi_arready,
   input wire s_axi_rvalid,
   input wire s_axi_rready,
   input wire [31:0] s_axi_rdata,
   // Pin and processor side.
   input wire ext_irq_n,
   input wire vector_fetch,
   input wire wait_mode,
   input wire stop_mode,
   input wire cpu_irq_req,
   input wire [15:0] cpu_vector_addr,
   input wire pin_level_to_cpu,
   input wire wake_req
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (reset);

   // Wake must track the unmasked request only while the core sleeps.
   a_wake_level: assert property (wake_req == (cpu_irq_req && (wait_mode || stop_mode)))
      else $error("wake request does not follow the request");
   a_vector_fixed: assert property (cpu_vector_addr == 16'hfffa)
      else $error("vector address is wrong");
   // The two-stage sampler needs two edges of history after reset.
   a_pin_follow: assert property (!$past(reset, 2) |-> pin_level_to_cpu == $past(ext_irq_n, 2))
      else $error("pin level is not the delayed pin");
   // A fetch with the pin high long enough leaves no edge pending, so the latch must drop.
   a_fetch_clears: assert property (vector_fetch && cpu_irq_req && ext_irq_n && $past(ext_irq_n)
      && $past(ext_irq_n, 2) && $past(ext_irq_n, 3) |=> !cpu_irq_req)
      else $error("vector fetch did not clear the request");
   a_write_refused: assert property (s_axi_bvalid |-> !s_axi_awready)
      else $error("write address taken while a response is pending");
   a_resp_drop: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
      else $error("write response repeated");
   a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid ##1 !s_axi_rvalid)
      else $error("read answer missing or repeated");
   a_read_steady: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data changed before it was taken");

   c_fetch: cover property (vector_fetch && cpu_irq_req);
   c_wake: cover property (wake_req);
   c_write: cover property (s_axi_bvalid);
endmodule

//--- dv/eip_cpu_model.sv
`timescale 1ns/100ps
// Processor side: takes the vector some cycles after an unmasked request.
module eip_cpu_model #(
   parameter DLY = 2
) (
   input wire core_clk,
   input wire reset,
   input wire cpu_irq_req,
   input wire fetch_en,
   output reg vector_fetch
);
   integer cnt;
   // A slow answer lets the pin settle first; the pulse lasts one cycle only.
   always @(posedge core_clk or posedge reset) begin
      if (reset) begin
         vector_fetch <= 1'b0;
         cnt <= 0;
      end else begin
         vector_fetch <= 1'b0;
         if (cpu_irq_req && fetch_en && !vector_fetch) begin
            if (cnt == DLY) begin
               vector_fetch <= 1'b1;
               cnt <= 0;
            end else begin
               cnt <= cnt + 1;
            end
         end else begin
            cnt <= 0;
         end
      end
   end
endmodule

//--- dv/test_external_interrupt_pin.sv
`timescale 1ns/100ps
module test_external_interrupt_pin;
   reg core_clk = 1'b0;
   reg reset = 1'b1;
   reg [3:0] awaddr = 4'h0;
   reg [3:0] araddr = 4'h0;
   reg [31:0] wdata = 32'h0;
   reg awvalid = 1'b0;
   reg wvalid = 1'b0;
   reg arvalid = 1'b0;
   reg pin_n = 1'b1;
   reg fetch_en = 1'b0;
   reg brk = 1'b0;
   reg wt_m = 1'b0;
   reg st_m = 1'b0;
   wire awready, wready, bvalid, arready, rvalid, vfetch, req, wake, irq;
   wire [1:0] rresp, bresp;
   wire [31:0] rdata;
   wire [2:0] outs = {wake, irq, req};
   integer fail_count = 0;
   integer samples_checked = 0;
   integer cyc = 0;

   // Half-period toggle gives the 4 ns clock.
   always #2 core_clk = ~core_clk;

   eirq_top uut (.core_clk(core_clk), .reset(reset), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(1'b1),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(1'b1), .ext_irq_n(pin_n),
      .vector_fetch(vfetch), .break_state(brk), .wait_mode(wt_m), .stop_mode(st_m), .cpu_irq_req(req),
      .cpu_vector_addr(), .pin_level_to_cpu(), .wake_req(wake), .irq_out(irq));

   eip_cpu_model #(.DLY(4)) cpu (.core_clk(core_clk), .reset(reset), .cpu_irq_req(req),
      .fetch_en(fetch_en), .vector_fetch(vfetch));

   task chk(input [31:0] seen, input [31:0] exp);
      begin
         samples_checked = samples_checked + 1;
         if (seen !== exp) begin
            fail_count = fail_count + 1;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
         end
      end
   endtask

   task close_out;
      begin
         $display("checks %0d, mismatches %0d", samples_checked, fail_count);
         if (fail_count == 0 && samples_checked > 0)
            $display("Finished cleanly");
         else
            $display("Finished with errors");
         $finish;
      end
   endtask

   task wt(input integer n);
      begin
         repeat (n) @(posedge core_clk);
      end
   endtask

   // Handshakes are judged at the falling edge, when the rising edge's updates have landed.
   task axw(input [3:0] a, input [31:0] d);
      reg ta, tw, tb;
      begin
         awaddr <= a;
         wdata <= d;
         awvalid <= 1'b1;
         wvalid <= 1'b1;
         tb = 1'b0;
         while (!tb) begin
            @(negedge core_clk);
            ta = awvalid & awready;
            tw = wvalid & wready;
            tb = bvalid;
            if (tb) chk({30'h0, bresp}, {30'h0, (a[1:0] == 2'b00) ? 2'b00 : 2'b10});
            @(posedge core_clk);
            if (ta) awvalid <= 1'b0;
            if (tw) wvalid <= 1'b0;
         end
      end
   endtask

   task axr(input [3:0] a, input [31:0] e, input [1:0] r);
      reg tr, tv;
      begin
         araddr <= a;
         arvalid <= 1'b1;
         tv = 1'b0;
         while (!tv) begin
            @(negedge core_clk);
            tr = arvalid & arready;
            tv = rvalid;
            if (tv) chk(rdata, e);
            if (tv) chk({30'h0, rresp}, {30'h0, r});
            @(posedge core_clk);
            if (tr) arvalid <= 1'b0;
         end
      end
   endtask

   // Compares wake, line and request under a mask of the bits that matter.
   task obs(input [2:0] e, input [2:0] m);
      begin
         @(negedge core_clk);
         chk({29'h0, outs & m}, {29'h0, e});
         @(posedge core_clk);
      end
   endtask

   // A hang ends the run as a failure.
   always @(posedge core_clk) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         fail_count = fail_count + 1;
         close_out;
      end
   end

   initial begin
      wt(3);
      reset <= 1'b0;
      wt(1);
      axr(4'h0, 32'h10, 2'b00);
      axr(4'h4, 32'h0, 2'b00);
      axw(4'hc, 32'h3);
      pin_n <= 1'b0;
      wt(4);
      obs(3'h3, 3'h7);
      axw(4'h0, 32'h4);
      obs(3'h2, 3'h7);
      axr(4'h0, 32'h0, 2'b00);
      axr(4'h8, 32'h1, 2'b00);
      obs(3'h0, 3'h7);
      pin_n <= 1'b1;
      wt(3);
      pin_n <= 1'b0;
      wt(4);
      obs(3'h1, 3'h1);
      pin_n <= 1'b1;
      fetch_en <= 1'b1;
      wt(8);
      obs(3'h0, 3'h1);
      fetch_en <= 1'b0;
      axw(4'h0, 32'h1);
      pin_n <= 1'b0;
      wt(4);
      obs(3'h1, 3'h1);
      axw(4'h0, 32'h5);
      wt(4);
      obs(3'h1, 3'h1);
      pin_n <= 1'b1;
      wt(4);
      obs(3'h0, 3'h1);
      pin_n <= 1'b0;
      wt(4);
      pin_n <= 1'b1;
      wt(4);
      obs(3'h1, 3'h1);
      axw(4'h0, 32'h5);
      obs(3'h0, 3'h1);
      axw(4'h0, 32'h3);
      pin_n <= 1'b0;
      wt(4);
      obs(3'h0, 3'h5);
      axr(4'h0, 32'hb, 2'b00);
      wt_m <= 1'b1;
      axw(4'h0, 32'h1);
      obs(3'h5, 3'h5);
      wt_m <= 1'b0;
      st_m <= 1'b1;
      obs(3'h5, 3'h5);
      axw(4'h0, 32'h3);
      obs(3'h0, 3'h5);
      st_m <= 1'b0;
      axw(4'h0, 32'h0);
      obs(3'h1, 3'h1);
      axw(4'h0, 32'h4);
      obs(3'h0, 3'h1);
      pin_n <= 1'b1;
      wt(3);
      pin_n <= 1'b0;
      wt(4);
      brk <= 1'b1;
      axw(4'h0, 32'h4);
      obs(3'h1, 3'h1);
      axw(4'h4, 32'h80);
      axr(4'h4, 32'h80, 2'b00);
      axw(4'h0, 32'h4);
      obs(3'h0, 3'h1);
      brk <= 1'b0;
      pin_n <= 1'b1;
      wt(2);
      obs(3'h0, 3'h1);
      axr(4'h8, 32'h3, 2'b00);
      axr(4'h2, 32'h0, 2'b10);
      axw(4'h6, 32'h7);
      axr(4'h0, 32'h10, 2'b00);
      close_out;
   end
endmodule

bind eirq_top eip_monitor mon (.core_clk, .reset, .s_axi_awready, .s_axi_bvalid, .s_axi_bready,
   .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .ext_irq_n,
   .vector_fetch, .wait_mode, .stop_mode, .cpu_irq_req, .cpu_vector_addr, .pin_level_to_cpu, .wake_req);
